// File: rtl/cfg_ack_cycle_gen.sv
// Configuration and interrupt-acknowledge cycle generator of the register channel
`include "cfg_ack_gen_map.svh"
`default_nettype none
// Summary of operation
// - Kind bit one: Type 1 address phase carries the whole address register.
// - Kind bit zero: Type 0, device index one-hot on AD[31:16].
// - Type 0: AD[15:11] zero, function, register index, AD[1:0] zero.
// - Address register bit 15 always reads and stays zero.
// - Local data write launches config write; local read launches config read.
// - PCI-side writes to config data ignored; PCI reads return zero.
// - Config data accesses complete as delayed transfers.
// - Config data access with bus master disabled gives local bus error.
// - Register channel data passes with no byte swapping.
// - Local read of acknowledge register launches acknowledge cycle, lanes from size.
// - Acknowledge cycle carries the local access address.
// - Acknowledge read retried until vector latched, returned on reissue.
// - Writes to acknowledge register do nothing; PCI reads return zero.
// - Acknowledge read with bus master disabled gives local bus error.
module cfg_ack_cycle_gen
   import cfg_ack_gen_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic        i_bus_master_enable,
   input  wire logic        i_loc_req,
   input  wire logic        i_loc_wr,
   input  wire logic [1:0]  i_loc_sel,
   input  wire logic [31:0] i_loc_addr,
   input  wire logic [1:0]  i_local_size_code,
   input  wire logic [31:0] i_loc_wdata,
   output logic             o_loc_ack,
   output logic             o_loc_retry,
   output logic             o_loc_err,
   output logic      [31:0] o_loc_rdata,
   input  wire logic        i_pci_req,
   input  wire logic        i_pci_wr,
   input  wire logic [1:0]  i_pci_sel,
   input  wire logic [31:0] i_pci_wdata,
   output logic             o_pci_ack,
   output logic      [31:0] o_pci_rdata,
   output logic             o_cyc_req,
   output cyc_kind_t        o_cyc_kind,
   output logic      [31:0] o_cyc_addr,
   output logic      [3:0]  o_cyc_be,
   output logic      [31:0] o_cyc_wdata,
   input  wire logic        i_cyc_done,
   input  wire logic [31:0] i_cyc_rdata
);
   pend_state_t state_reg, state_next;
   cyc_kind_t   kind_reg, kind_next;
   logic [31:0] cfg_addr_reg, cfg_addr_next;
   logic [31:0] cyc_addr_reg, cyc_addr_next;
   logic [31:0] wdata_reg, wdata_next;
   logic [31:0] data_reg, data_next;
   logic [3:0]  be_reg, be_next;
   logic        ack_reg, ack_next;
   logic        retry_reg, retry_next;
   logic        err_reg, err_next;
   logic [31:0] loc_rdata_reg, loc_rdata_next;
   logic        pci_ack_reg, pci_ack_next;
   logic [31:0] pci_rdata_reg, pci_rdata_next;
   logic [31:0] encoded_ad;
   logic        delayed_acc;
   cyc_kind_t   acc_kind;
   logic [3:0]  size_mask;

   cfg_addr_encoder u_encoder (
      .i_cfg_addr (cfg_addr_reg),
      .o_ad       (encoded_ad)
   );

   // Lane mask widened from the size code, then shifted to the start lane
   always_comb begin
      unique case (i_local_size_code)
         `SIZE_BYTE:   size_mask = 4'h1;
         `SIZE_WORD:   size_mask = 4'h3;
         `SIZE_TRIPLE: size_mask = 4'h7;
         `SIZE_LONG:   size_mask = 4'hf;
      endcase
   end

   // Ack register writes are not delayed: they complete at once with no effect
   assign delayed_acc = i_loc_req && ((i_loc_sel == `SEL_CFG_DATA) ||
                        (i_loc_sel == `SEL_ACK_GEN && !i_loc_wr));
   assign acc_kind = (i_loc_sel == `SEL_ACK_GEN) ? CYC_ACK :
                     (i_loc_wr ? CYC_CFG_WRITE : CYC_CFG_READ);

   always_comb begin
      state_next     = state_reg;
      kind_next      = kind_reg;
      cfg_addr_next  = cfg_addr_reg;
      cyc_addr_next  = cyc_addr_reg;
      wdata_next     = wdata_reg;
      data_next      = data_reg;
      be_next        = be_reg;
      ack_next       = 1'b0;
      retry_next     = 1'b0;
      err_next       = 1'b0;
      loc_rdata_next = loc_rdata_reg;
      pci_ack_next   = 1'b0;
      pci_rdata_next = pci_rdata_reg;

      if (state_reg == ST_ISSUE && i_cyc_done) begin
         data_next  = i_cyc_rdata;
         state_next = ST_READY;
      end

      if (i_loc_req && !delayed_acc) begin
         ack_next = 1'b1;
         if (i_loc_sel == `SEL_CFG_ADDR) begin
            if (i_loc_wr) begin
               cfg_addr_next = i_loc_wdata & `CA_WRITE_MASK;
            end else begin
               loc_rdata_next = cfg_addr_reg;
            end
         end else if (!i_loc_wr) begin
            loc_rdata_next = 32'h0000_0000;
         end
      end else if (delayed_acc && !i_bus_master_enable) begin
         err_next = 1'b1;
      end else if (delayed_acc) begin
         unique case (state_reg)
            ST_IDLE: begin
               retry_next = 1'b1;
               state_next = ST_ISSUE;
               kind_next  = acc_kind;
               wdata_next = i_loc_wdata;
               if (acc_kind == CYC_ACK) begin
                  cyc_addr_next = i_loc_addr;
                  be_next       = 4'((size_mask << i_loc_addr[1:0]) & 4'hf);
               end else begin
                  cyc_addr_next = encoded_ad;
                  be_next       = 4'hf;
               end
            end
            ST_ISSUE: begin
               retry_next = 1'b1;
            end
            ST_READY: begin
               if (acc_kind == kind_reg && !i_cyc_done) begin
                  ack_next       = 1'b1;
                  loc_rdata_next = (kind_reg == CYC_CFG_WRITE) ? 32'h0000_0000 : data_reg;
                  state_next     = ST_IDLE;
               end else begin
                  retry_next = 1'b1;
               end
            end
            default: begin
               state_next = ST_IDLE;
            end
         endcase
      end

      // PCI-side register port; data and ack registers look empty from here
      if (i_pci_req) begin
         pci_ack_next = 1'b1;
         if (i_pci_sel == `SEL_CFG_ADDR) begin
            if (i_pci_wr) begin
               cfg_addr_next = i_pci_wdata & `CA_WRITE_MASK;
            end else begin
               pci_rdata_next = cfg_addr_reg;
            end
         end else if (!i_pci_wr) begin
            pci_rdata_next = 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state_reg     <= ST_IDLE;
         kind_reg      <= CYC_CFG_READ;
         cfg_addr_reg  <= `CA_RESET;
         cyc_addr_reg  <= 32'h0000_0000;
         wdata_reg     <= 32'h0000_0000;
         data_reg      <= 32'h0000_0000;
         be_reg        <= 4'h0;
         ack_reg       <= 1'b0;
         retry_reg     <= 1'b0;
         err_reg       <= 1'b0;
         loc_rdata_reg <= 32'h0000_0000;
         pci_ack_reg   <= 1'b0;
         pci_rdata_reg <= 32'h0000_0000;
      end else begin
         state_reg     <= state_next;
         kind_reg      <= kind_next;
         cfg_addr_reg  <= cfg_addr_next;
         cyc_addr_reg  <= cyc_addr_next;
         wdata_reg     <= wdata_next;
         data_reg      <= data_next;
         be_reg        <= be_next;
         ack_reg       <= ack_next;
         retry_reg     <= retry_next;
         err_reg       <= err_next;
         loc_rdata_reg <= loc_rdata_next;
         pci_ack_reg   <= pci_ack_next;
         pci_rdata_reg <= pci_rdata_next;
      end
   end

   assign o_loc_ack   = ack_reg;
   assign o_loc_retry = retry_reg;
   assign o_loc_err   = err_reg;
   assign o_loc_rdata = loc_rdata_reg;
   assign o_pci_ack   = pci_ack_reg;
   assign o_pci_rdata = pci_rdata_reg;
   assign o_cyc_req   = (state_reg == ST_ISSUE);
   assign o_cyc_kind  = kind_reg;
   assign o_cyc_addr  = cyc_addr_reg;
   assign o_cyc_be    = be_reg;
   assign o_cyc_wdata = wdata_reg;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   a_type1_addr_copy: assert property (
      (o_cyc_req && !$past(o_cyc_req) && o_cyc_kind != CYC_ACK && $past(cfg_addr_reg[0]))
      |-> o_cyc_addr == $past(cfg_addr_reg))
      else $error("Type 1 address differs from address register");
   a_type0_onehot: assert property (
      (o_cyc_req && o_cyc_kind != CYC_ACK && !o_cyc_addr[0]) |-> $onehot(o_cyc_addr[31:16]))
      else $error("Type 0 device select not one-hot");
   a_type0_low_zero: assert property (
      (o_cyc_req && o_cyc_kind != CYC_ACK && o_cyc_addr[31:16] != 16'h0 && !o_cyc_addr[0])
      |-> o_cyc_addr[15:11] == 5'h00 && o_cyc_addr[1:0] == 2'h0)
      else $error("Type 0 low address lines not zero");
   a_bit15_zero: assert property (
      cfg_addr_reg[`CA_FIXED_ZERO_BIT] == 1'b0)
      else $error("Address register bit 15 set");
   a_pci_data_zero: assert property (
      (i_pci_req && !i_pci_wr && i_pci_sel != `SEL_CFG_ADDR) |=> o_pci_ack && o_pci_rdata == 32'h0)
      else $error("PCI read of data register not zero");
   a_first_retry: assert property (
      (delayed_acc && i_bus_master_enable && state_reg == ST_IDLE)
      |=> o_loc_retry && !o_loc_ack ##0 o_cyc_req)
      else $error("Delayed access not retried and launched");
   a_bme_error: assert property (
      (delayed_acc && !i_bus_master_enable) |=> o_loc_err && !o_loc_ack && !o_loc_retry)
      else $error("Access with bus master off not errored");
   a_ack_vector: assert property (
      (state_reg == ST_ISSUE && i_cyc_done && kind_reg == CYC_ACK)
      ##1 (delayed_acc && i_bus_master_enable && acc_kind == CYC_ACK && !i_cyc_done)
      |=> o_loc_ack && o_loc_rdata == $past(i_cyc_rdata, 2))
      else $error("Acknowledge vector not returned");
   a_once_only: assert property (
      o_loc_ack && $past(state_reg) == ST_READY && $past(delayed_acc) |-> state_reg == ST_IDLE)
      else $error("Completed data given twice");
endmodule : cfg_ack_cycle_gen
`default_nettype wire

// File: pkg/cfg_ack_gen_map.svh
// Field positions, reset values, select codes and size codes for the cycle generator
`ifndef CFG_ACK_GEN_MAP_SVH
`define CFG_ACK_GEN_MAP_SVH

// Register select codes on both register ports
`define SEL_CFG_ADDR      2'h0
`define SEL_CFG_DATA      2'h1
`define SEL_ACK_GEN       2'h2

// Fields of config_cycle_address
`define CA_KIND_BIT       0
`define CA_REG_LSB        2
`define CA_REG_MSB        7
`define CA_FUNC_LSB       8
`define CA_FUNC_MSB       10
`define CA_DEV_LSB        11
`define CA_DEV_MSB        14
`define CA_FIXED_ZERO_BIT 15
`define CA_RESET          32'h0000_0000
`define CA_WRITE_MASK     32'hffff_7fff

// Type 0 one-hot device select base line
`define T0_SEL_BASE       16

// Local transfer size codes
`define SIZE_LONG         2'h0
`define SIZE_BYTE         2'h1
`define SIZE_WORD         2'h2
`define SIZE_TRIPLE       2'h3

`endif

// File: pkg/cfg_ack_gen_pkg.sv
// Types shared by the configuration and acknowledge cycle generator
`default_nettype none
package cfg_ack_gen_pkg;
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_ISSUE = 2'b01,
      ST_READY = 2'b10
   } pend_state_t;

   typedef enum logic [1:0] {
      CYC_CFG_READ  = 2'b00,
      CYC_CFG_WRITE = 2'b01,
      CYC_ACK       = 2'b10
   } cyc_kind_t;
endpackage : cfg_ack_gen_pkg
`default_nettype wire

// File: rtl/cfg_addr_encoder.sv
// Address phase encoder for Type 0 and Type 1 configuration cycles
`include "cfg_ack_gen_map.svh"
`default_nettype none
module cfg_addr_encoder (
   input  wire logic [31:0] i_cfg_addr,
   output logic      [31:0] o_ad
);
   logic [15:0] dev_onehot;

   always_comb begin
      dev_onehot = 16'h0000;
      dev_onehot[i_cfg_addr[`CA_DEV_MSB:`CA_DEV_LSB]] = 1'b1;
      if (i_cfg_addr[`CA_KIND_BIT]) begin
         o_ad = i_cfg_addr;
      end else begin
         o_ad = {dev_onehot, 5'h00, i_cfg_addr[`CA_FUNC_MSB:`CA_FUNC_LSB],
                 i_cfg_addr[`CA_REG_MSB:`CA_REG_LSB], 2'h0};
      end
   end
endmodule : cfg_addr_encoder
`default_nettype wire

// File: tb/pci_target_model.sv
// Behavioural PCI target that answers the generator's bus cycles
`default_nettype none
module pci_target_model (
   input  wire logic        i_clk,
   input  wire logic        i_req,
   output logic             o_done,
   output logic      [31:0] o_rdata,
   output logic      [31:0] o_last
);
   timeunit 1ns;
   timeprecision 1ps;
   // Random wait per cycle, so prompt and slow targets are both seen
   initial begin
      o_done = 1'b0;
      o_rdata = 32'h0;
      o_last = 32'h0;
      forever begin
         @(posedge i_clk iff i_req === 1'b1);
         repeat ($urandom_range(0, 5)) @(posedge i_clk);
         #1 o_done = 1'b1;
         o_rdata = $urandom;
         o_last = o_rdata;
         @(posedge i_clk);
         #1 o_done = 1'b0;
         o_rdata = ~o_rdata; // Stale data must never look valid
         @(posedge i_clk);
      end
   end
endmodule : pci_target_model
`default_nettype wire

// File: tb/test_pci_config_ack_cycle_generator.sv
// Self-checking bench for the configuration and acknowledge cycle generator
`default_nettype none
module test_pci_config_ack_cycle_generator;
   timeunit 1ns;
   timeprecision 1ps;
   import cfg_ack_gen_pkg::*;
   logic i_clk, i_rst, i_bus_master_enable, i_loc_req, i_loc_wr, o_loc_ack, o_loc_retry;
   logic o_loc_err, i_pci_req, i_pci_wr, o_pci_ack, o_cyc_req, i_cyc_done;
   logic [1:0] i_loc_sel, i_local_size_code, i_pci_sel;
   logic [3:0] o_cyc_be;
   logic [31:0] i_loc_addr, i_loc_wdata, o_loc_rdata, i_pci_wdata, o_pci_rdata;
   logic [31:0] o_cyc_addr, o_cyc_wdata, i_cyc_rdata, last, car, a;
   cyc_kind_t o_cyc_kind;
   logic [2:0] rsp;
   logic [31:0] rd;
   int miscompares = 0;
   int checks_done = 0;

   cfg_ack_cycle_gen cfg_ack_cycle_gen_i (.i_clk, .i_rst, .i_bus_master_enable, .i_loc_req,
      .i_loc_wr, .i_loc_sel, .i_loc_addr, .i_local_size_code, .i_loc_wdata, .o_loc_ack,
      .o_loc_retry, .o_loc_err, .o_loc_rdata, .i_pci_req, .i_pci_wr, .i_pci_sel,
      .i_pci_wdata, .o_pci_ack, .o_pci_rdata, .o_cyc_req, .o_cyc_kind, .o_cyc_addr,
      .o_cyc_be, .o_cyc_wdata, .i_cyc_done, .i_cyc_rdata);
   pci_target_model pci_target_model_i (.i_clk, .i_req(o_cyc_req), .o_done(i_cyc_done),
      .o_rdata(i_cyc_rdata), .o_last(last));

   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end

   task automatic end_sim();
      if (miscompares == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : end_sim

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   // Type 0 one-hot select, or the whole register for Type 1
   function automatic logic [31:0] ad_of(input logic [31:0] r);
      if (r[0]) return r;
      return (32'h1 << (16 + r[14:11])) | {21'h0, r[10:2], 2'h0};
   endfunction : ad_of

   function automatic logic [3:0] be_of(input logic [1:0] z, input logic [1:0] s);
      logic [7:0] m;
      m = (z == 2'h0) ? 8'h0f : (8'h1 << z) - 8'h1;
      return 4'(m << s);
   endfunction : be_of

   task automatic xfer(input logic w, input logic [1:0] s, input logic [31:0] ad,
                       input logic [1:0] z, input logic [31:0] d);
      @(posedge i_clk);
      #1 i_loc_req = 1'b1;
      i_loc_wr = w;
      i_loc_sel = s;
      i_loc_addr = ad;
      i_local_size_code = z;
      i_loc_wdata = d;
      @(posedge i_clk);
      #1 i_loc_req = 1'b0;
      rsp = {o_loc_err, o_loc_retry, o_loc_ack};
      rd = o_loc_rdata;
   endtask : xfer

   task automatic preq(input logic w, input logic [1:0] s, input logic [31:0] d,
                       input logic [31:0] e);
      @(posedge i_clk);
      #1 i_pci_req = 1'b1;
      i_pci_wr = w;
      i_pci_sel = s;
      i_pci_wdata = d;
      @(posedge i_clk);
      #1 i_pci_req = 1'b0;
      chk("pci_ack", 32'h1, o_pci_ack);
      if (!w) chk("pci_rdata", e, o_pci_rdata);
      chk("cyc_req_idle", 32'h0, o_cyc_req);
   endtask : preq

   // Retried first, then completed once on reissue
   task automatic dly(input logic w, input logic [1:0] s, input logic [31:0] ad,
                      input logic [1:0] z, input logic [31:0] d, input logic [31:0] ea);
      int n;
      xfer(w, s, ad, z, d);
      chk("resp", 3'b010, rsp);
      chk("kind", (s == 2'h2) ? 2'h2 : {1'b0, w}, o_cyc_kind);
      chk("cyc_addr", ea, o_cyc_addr);
      if (s == 2'h2) chk("be", be_of(z, ad[1:0]), o_cyc_be);
      else chk("be", 32'hf, o_cyc_be);
      if (w) chk("cyc_wdata", d, o_cyc_wdata);
      // Reissue on the first edge after the target answers, the tightest legal case
      n = 0;
      while (i_cyc_done !== 1'b1 && n < 40) begin
         @(posedge i_clk);
         #2;
         n++;
      end
      xfer(w, s, ad, z, d);
      chk("resp", 3'b001, rsp);
      chk("rdata", w ? 32'h0 : last, rd);
      chk("cyc_req_idle", 32'h0, o_cyc_req);
   endtask : dly

   initial begin
      repeat (5000) @(posedge i_clk);
      miscompares++;
      end_sim();
   end

   initial begin
      {i_rst, i_bus_master_enable} = 2'b11;
      {i_loc_req, i_loc_wr, i_pci_req, i_pci_wr} = 4'h0;
      {i_loc_sel, i_local_size_code, i_pci_sel} = 6'h0;
      {i_loc_addr, i_loc_wdata, i_pci_wdata} = 96'h0;
      void'($urandom(32'h4edd2afd));
      repeat (2) @(posedge i_clk);
      #1 i_rst = 1'b0;
      for (int i = 0; i < 16; i++) begin
         car = $urandom;
         car[14:11] = i[3:0];
         car[0] = 1'b0;
         xfer(1'b1, 2'h0, 32'h0, 2'h0, car);
         chk("addr_wr_resp", 3'b001, rsp);
         car[15] = 1'b0;
         xfer(1'b0, 2'h0, 32'h0, 2'h0, 32'h0);
         chk("addr_reg", car, rd);
         dly(1'b0, 2'h1, 32'h0, 2'h0, 32'h0, ad_of(car));
      end
      car = $urandom | 32'h1;
      preq(1'b1, 2'h0, car, 32'h0);
      car[15] = 1'b0;
      preq(1'b0, 2'h0, 32'h0, car);
      dly(1'b1, 2'h1, 32'h0, 2'h0, $urandom, car);
      dly(1'b0, 2'h1, 32'h0, 2'h0, 32'h0, car);
      for (int z = 0; z < 8; z++) begin
         a = $urandom;
         dly(1'b0, 2'h2, a, z[1:0], 32'h0, a);
      end
      preq(1'b1, 2'h1, $urandom, 32'h0);
      preq(1'b0, 2'h1, 32'h0, 32'h0);
      preq(1'b1, 2'h2, $urandom, 32'h0);
      preq(1'b0, 2'h2, 32'h0, 32'h0);
      xfer(1'b1, 2'h2, $urandom, 2'h0, $urandom);
      chk("resp", 3'b001, rsp);
      chk("cyc_req_idle", 32'h0, o_cyc_req);
      xfer(1'b0, 2'h0, 32'h0, 2'h0, 32'h0);
      chk("addr_kept", car, rd);
      i_bus_master_enable = 1'b0;
      for (int k = 0; k < 3; k++) begin
         xfer(k[0], (k < 2) ? 2'h1 : 2'h2, 32'h0, 2'h0, 32'h0);
         chk("resp", 3'b100, rsp);
         chk("cyc_req_idle", 32'h0, o_cyc_req);
      end
      // Reset while a cycle is pending must drop it and clear the address register
      i_bus_master_enable = 1'b1;
      xfer(1'b0, 2'h1, 32'h0, 2'h0, 32'h0);
      chk("resp", 3'b010, rsp);
      @(posedge i_clk);
      #1 i_rst = 1'b1;
      repeat (2) @(posedge i_clk);
      #1 i_rst = 1'b0;
      chk("cyc_req_rst", 32'h0, o_cyc_req);
      chk("loc_rdata_rst", 32'h0, o_loc_rdata);
      xfer(1'b0, 2'h0, 32'h0, 2'h0, 32'h0);
      chk("addr_reg_rst", 32'h0, rd);
      repeat (10) @(posedge i_clk);
      dly(1'b0, 2'h1, 32'h0, 2'h0, 32'h0, 32'h0001_0000);
      end_sim();
   end
endmodule : test_pci_config_ack_cycle_generator
`default_nettype wire
